// ---- core/drive_controller.sv ----
// Controller end: APB register front for the fieldbus master and safety controller
`timescale 1ns/1ps
`default_nettype none
`include "drive_io_params.svh"

module drive_controller #(
    parameter int STO_DELAY = `STO_DELAY_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    drive_io_if.controller   link
);

    if (STO_DELAY < 1 || STO_DELAY > 65535) begin
        $error("drive_controller: unsupported STO_DELAY");
    end

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    logic setup;
    logic hit;
    assign setup = psel && !penable;

    always_comb begin
        if (paddr == `REG_CTRL || paddr == `REG_CTRL_WORD)
            hit = 1'b1;
        else if (paddr == `REG_STATUS || paddr == `REG_LEVELS || paddr == `REG_RELAY)
            hit = 1'b1;
        else
            hit = 1'b0;
    end

    logic [31:0] ctrl_q;
    logic [15:0] cw_q;
    logic        cw_valid_q;
    logic [31:0] rdata_q;
    logic        ready_q;
    logic        err_q;

    // Zero-wait slave: answer is prepared during setup, shown in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            ready_q <= setup;
            err_q   <= setup && !hit;
            if (setup && !pwrite) begin
                if (paddr == `REG_CTRL)
                    rdata_q <= ctrl_q;
                else if (paddr == `REG_CTRL_WORD)
                    rdata_q <= {16'h0000, cw_q};
                else if (paddr == `REG_STATUS)
                    rdata_q <= {16'h0000, link.status_word};
                else if (paddr == `REG_LEVELS)
                    rdata_q <= {link.dout_levels[15:0], link.din_levels[15:0]};
                else if (paddr == `REG_RELAY)
                    rdata_q <= {30'h0000_0000, link.relay_cmd};
                else
                    rdata_q <= 32'h0000_0000;
            end
        end
    end

    logic wr_access;
    assign wr_access = psel && penable && pwrite && ready_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= `CTRL_RESET;
            cw_q       <= 16'h0000;
            cw_valid_q <= 1'b0;
        end else begin
            cw_valid_q <= 1'b0;
            if (wr_access && paddr == `REG_CTRL)
                ctrl_q <= {24'h00_0000, pwdata[7:0]};
            if (wr_access && paddr == `REG_CTRL_WORD) begin
                cw_q       <= pwdata[15:0];
                cw_valid_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Controlled stop: stop, wait out of run, delay, then torque-off
    // ------------------------------------------------------------------------
    drive_io_pkg::safe_stop_t ss_q;
    logic [15:0] delay_q;
    logic        running;
    assign running = (link.status_word & 16'h006f) == `SW_CODE_OP_ENABLED;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_q    <= drive_io_pkg::SS_IDLE;
            delay_q <= 16'h0000;
        end else begin
            case (ss_q)
                drive_io_pkg::SS_IDLE: begin
                    if (ctrl_q[`CTRL_BIT_SAFE_STOP])
                        ss_q <= drive_io_pkg::SS_STOP;
                end
                drive_io_pkg::SS_STOP: begin
                    if (!running) begin
                        ss_q    <= drive_io_pkg::SS_DELAY;
                        delay_q <= 16'(STO_DELAY);
                    end
                end
                drive_io_pkg::SS_DELAY: begin
                    if (delay_q == 16'h0001)
                        ss_q <= drive_io_pkg::SS_HOLD;
                    delay_q <= delay_q - 16'h0001;
                end
                drive_io_pkg::SS_HOLD: begin
                    if (!ctrl_q[`CTRL_BIT_SAFE_STOP])
                        ss_q <= drive_io_pkg::SS_IDLE;
                end
                default: ss_q <= drive_io_pkg::SS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Link drive
    // ------------------------------------------------------------------------
    logic [3:0] din_q;
    logic [1:0] sto_q;
    logic       fb_q;
    logic       sto_req;
    assign sto_req = |ctrl_q[`CTRL_STO_LSB +: 2] || ss_q == drive_io_pkg::SS_HOLD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_q <= 4'h0;
            sto_q <= 2'h0;
            fb_q  <= 1'b0;
        end else begin
            din_q <= ctrl_q[`CTRL_DIN_LSB +: 4];
            // Run is held off while torque-off is requested so recovery sees both low
            if (sto_req || ss_q != drive_io_pkg::SS_IDLE)
                din_q[0] <= 1'b0;
            if (ss_q == drive_io_pkg::SS_STOP)
                din_q[1] <= 1'b1;
            sto_q <= ctrl_q[`CTRL_STO_LSB +: 2] | {2{ss_q == drive_io_pkg::SS_HOLD}};
            fb_q  <= ctrl_q[`CTRL_BIT_FIELDBUS];
        end
    end

    assign prdata               = rdata_q;
    assign pready               = ready_q;
    assign pslverr              = err_q;
    assign link.din             = din_q;
    assign link.safe_torque_off             = sto_q;
    assign link.fieldbus_mode   = fb_q;
    assign link.ctrl_word       = cw_q;
    assign link.ctrl_word_valid = cw_valid_q;

endmodule

`default_nettype wire

// ---- core/drive_supervisor.sv ----
// Drive end: digital I/O, overspeed and safe-torque-off state supervision
// How it works
// - Overspeed alarm above limit plus ten percent
// - Four inputs, four outputs, two safety inputs
// - Input functions fire on rising edges
// - Output function active means output driven high
// - Analog mode: input one runs, two stops
// - Emergency input drops run to standby, braking
// - Hardware reset input, qualified by hold timeout
// - Fieldbus mode follows control word, ignores run/stop
// - Output one high healthy, low in fault
// - Output two high while warning pending
// - Output three high when run is reachable
// - Output four high while brake released
// - Safe-torque-off forces safety state always
// - Detected fault enters fault state
// - Leave safety only with torque-off, run low
// - Analog recovery goes safety, standby, run
// - Fieldbus recovery steps through SOD, ready, switched on, then run
// - Controller stops, disables, then delays torque-off
// - Safety relay commands individually readable
// - No torque while safe-torque-off active
// - Status bit 8 follows emergency input
// - Status bit 14 reports safety state
`timescale 1ns/1ps
`default_nettype none
`include "drive_io_params.svh"

module drive_supervisor #(
    parameter int SPEED_W       = 16,
    parameter int HW_RESET_HOLD = `HW_RESET_HOLD_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    drive_io_if.device              link,
    input  wire logic [SPEED_W-1:0] motor_speed,
    input  wire logic [SPEED_W-1:0] max_velocity,
    input  wire logic               fault_detected,
    input  wire logic               warning_pending,
    output logic                    torque_enable,
    output logic                    dynamic_brake,
    output logic                    overspeed_alarm,
    output logic [2:0]              drive_state
);

    if (SPEED_W < 4 || SPEED_W > 30 || HW_RESET_HOLD < 1) begin
        $error("drive_supervisor: unsupported parameter values");
    end

    // ------------------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------------------
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic [5:0] prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 6'h00;
            sync_q <= 6'h00;
            prev_q <= 6'h00;
        end else begin
            meta_q <= {link.safe_torque_off, link.din};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    logic [3:0] din_s;
    logic [3:0] din_rise;
    logic       sto_active;
    assign din_s      = sync_q[3:0];
    assign din_rise   = sync_q[3:0] & ~prev_q[3:0];
    assign sto_active = |sync_q[5:4];

    // ------------------------------------------------------------------------
    // Overspeed: speed above limit + limit/10
    // ------------------------------------------------------------------------
    // Five spare bits so the product with the percentage cannot wrap at high limits
    function automatic logic [SPEED_W+1:0] speed_limit(input logic [SPEED_W-1:0] vmax);
        logic [SPEED_W+4:0] wide;
        wide = {5'h00, vmax};
        wide = wide + (wide * (SPEED_W+5)'(`OVERSPEED_PERCENT)) / (SPEED_W+5)'(100);
        return wide[SPEED_W+1:0];
    endfunction

    logic overspeed_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            overspeed_q <= 1'b0;
        else
            overspeed_q <= {2'b00, motor_speed} > speed_limit(max_velocity);
    end

    // ------------------------------------------------------------------------
    // Hardware reset qualification: input must stay high for the hold time
    // ------------------------------------------------------------------------
    logic [31:0] hold_cnt_q;
    logic        hw_reset_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_q <= 32'h0000_0000;
            hw_reset_q <= 1'b0;
        end else begin
            hw_reset_q <= 1'b0;
            if (!din_s[3]) begin
                hold_cnt_q <= 32'h0000_0000;
            end else if (din_rise[3]) begin
                hold_cnt_q <= 32'h0000_0001;
            end else if (hold_cnt_q != 32'h0000_0000) begin
                // A held level fires once; a glitch shorter than the hold is ignored
                if (hold_cnt_q == 32'(HW_RESET_HOLD)) begin
                    hold_cnt_q <= 32'h0000_0000;
                    hw_reset_q <= 1'b1;
                end else begin
                    hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Drive state machine
    // ------------------------------------------------------------------------
    drive_io_pkg::drive_state_t state_q;
    drive_io_pkg::drive_state_t state_d;
    logic [15:0] cw;
    logic        cw_cmd;
    logic        recover_ok;
    assign cw         = link.ctrl_word & `CW_MASK;
    assign cw_cmd     = link.fieldbus_mode && link.ctrl_word_valid;
    assign recover_ok = !sto_active && !din_s[0];

    always_comb begin
        state_d = state_q;
        case (state_q)
            drive_io_pkg::ST_SOD: begin
                if (cw_cmd && cw == `CW_SHUTDOWN)
                    state_d = drive_io_pkg::ST_READY;
            end
            drive_io_pkg::ST_READY: begin
                if (cw_cmd && cw == `CW_SWITCH_ON)
                    state_d = drive_io_pkg::ST_SWITCHED_ON;
            end
            drive_io_pkg::ST_SWITCHED_ON: begin
                if (din_s[2])
                    state_d = drive_io_pkg::ST_SWITCHED_ON;
                else if (link.fieldbus_mode && cw_cmd && cw == `CW_ENABLE_OP)
                    state_d = drive_io_pkg::ST_OP_ENABLED;
                else if (!link.fieldbus_mode && din_rise[0] && !din_s[1])
                    state_d = drive_io_pkg::ST_OP_ENABLED;
            end
            drive_io_pkg::ST_OP_ENABLED: begin
                if (din_rise[2])
                    state_d = drive_io_pkg::ST_SWITCHED_ON;
                else if (link.fieldbus_mode && cw_cmd && cw == `CW_SWITCH_ON)
                    state_d = drive_io_pkg::ST_SWITCHED_ON;
                else if (!link.fieldbus_mode && din_rise[1])
                    state_d = drive_io_pkg::ST_SWITCHED_ON;
            end
            drive_io_pkg::ST_SAFETY: begin
                if (recover_ok)
                    state_d = link.fieldbus_mode ? drive_io_pkg::ST_SOD
                                                 : drive_io_pkg::ST_SWITCHED_ON;
            end
            drive_io_pkg::ST_FAULT: begin
                if (hw_reset_q || (cw_cmd && link.ctrl_word[`CW_BIT_FAULT_RESET]))
                    state_d = link.fieldbus_mode ? drive_io_pkg::ST_SOD
                                                 : drive_io_pkg::ST_SWITCHED_ON;
            end
            default: state_d = drive_io_pkg::ST_SOD;
        endcase
        // Safety outranks fault so a live torque-off is never masked
        if (sto_active)
            state_d = drive_io_pkg::ST_SAFETY;
        else if (fault_detected || overspeed_q)
            state_d = drive_io_pkg::ST_FAULT;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_q <= drive_io_pkg::ST_SOD;
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    function automatic logic [15:0] state_code(input drive_io_pkg::drive_state_t s);
        case (s)
            drive_io_pkg::ST_SOD:         return `SW_CODE_SOD;
            drive_io_pkg::ST_READY:       return `SW_CODE_READY;
            drive_io_pkg::ST_SWITCHED_ON: return `SW_CODE_SWITCHED_ON;
            drive_io_pkg::ST_OP_ENABLED:  return `SW_CODE_OP_ENABLED;
            drive_io_pkg::ST_FAULT:       return `SW_CODE_FAULT;
            default:                      return `SW_CODE_SAFETY;
        endcase
    endfunction

    logic [3:0]  dout_d;
    logic [15:0] status_d;
    always_comb begin
        dout_d[0] = state_d != drive_io_pkg::ST_FAULT;
        dout_d[1] = warning_pending || overspeed_q;
        dout_d[2] = state_d == drive_io_pkg::ST_SWITCHED_ON && !din_s[2];
        dout_d[3] = state_d == drive_io_pkg::ST_OP_ENABLED;
        status_d  = state_code(state_d);
        status_d[`SW_BIT_EMERGENCY] = din_s[2];
        status_d[`SW_BIT_SAFETY]    = state_d == drive_io_pkg::ST_SAFETY;
    end

    logic [3:0]  dout_q;
    logic [15:0] status_q;
    logic [31:0] din_lvl_q;
    logic [1:0]  relay_q;
    logic        torque_q;
    logic        brake_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_q    <= 4'h0;
            status_q  <= `SW_CODE_SOD;
            din_lvl_q <= 32'h0000_0000;
            relay_q   <= 2'h0;
            torque_q  <= 1'b0;
            brake_q   <= 1'b0;
        end else begin
            dout_q    <= dout_d;
            status_q  <= status_d;
            din_lvl_q <= {28'h000_0000, din_s};
            relay_q   <= sync_q[5:4];
            torque_q  <= state_d == drive_io_pkg::ST_OP_ENABLED && !sto_active;
            brake_q   <= state_q == drive_io_pkg::ST_OP_ENABLED && din_rise[2];
        end
    end

    assign link.dout        = dout_q;
    assign link.status_word = status_q;
    assign link.din_levels  = din_lvl_q;
    assign link.dout_levels = {28'h000_0000, dout_q};
    assign link.relay_cmd   = relay_q;
    assign torque_enable    = torque_q;
    assign dynamic_brake    = brake_q;
    assign overspeed_alarm  = overspeed_q;
    assign drive_state      = state_q;

endmodule

`default_nettype wire

// ---- inc/drive_io_if.sv ----
// Link between the drive supervisor and its fieldbus/safety controller
`timescale 1ns/1ps
`default_nettype none

interface drive_io_if;
    logic [3:0]  din;
    logic [1:0]  safe_torque_off;
    logic        fieldbus_mode;
    logic [15:0] ctrl_word;
    logic        ctrl_word_valid;
    logic [15:0] status_word;
    logic [3:0]  dout;
    logic [31:0] din_levels;
    logic [31:0] dout_levels;
    logic [1:0]  relay_cmd;

    modport device (
        input  din,
        input  safe_torque_off,
        input  fieldbus_mode,
        input  ctrl_word,
        input  ctrl_word_valid,
        output status_word,
        output dout,
        output din_levels,
        output dout_levels,
        output relay_cmd
    );

    modport controller (
        output din,
        output safe_torque_off,
        output fieldbus_mode,
        output ctrl_word,
        output ctrl_word_valid,
        input  status_word,
        input  dout,
        input  din_levels,
        input  dout_levels,
        input  relay_cmd
    );
endinterface

`default_nettype wire

// ---- inc/drive_io_params.svh ----
// Offsets, field positions, reset values and timing counts for the drive I/O supervisor
`ifndef DRIVE_IO_PARAMS_SVH
`define DRIVE_IO_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS        4
`define HW_RESET_HOLD_NS     10000
`define HW_RESET_HOLD_CYC    ((`HW_RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STO_DELAY_NS         1000
`define STO_DELAY_CYC        ((`STO_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVERSPEED_PERCENT    10

// ----------------------------------------------------------------------------
// Device object indices
// ----------------------------------------------------------------------------
`define OBJ_DIGITAL_INPUT_LEVELS   16'h60fd
`define OBJ_DIGITAL_OUTPUT_LEVELS  16'h60fe

// ----------------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------------
`define SW_BIT_EMERGENCY     8
`define SW_BIT_SAFETY        14
`define SW_CODE_SOD          16'h0040
`define SW_CODE_READY        16'h0021
`define SW_CODE_SWITCHED_ON  16'h0023
`define SW_CODE_OP_ENABLED   16'h0027
`define SW_CODE_FAULT        16'h0008
`define SW_CODE_SAFETY       16'h0000

// ----------------------------------------------------------------------------
// Control word commands and fields
// ----------------------------------------------------------------------------
`define CW_MASK              16'h008f
`define CW_SHUTDOWN          16'h0006
`define CW_SWITCH_ON         16'h0007
`define CW_ENABLE_OP         16'h000f
`define CW_BIT_FAULT_RESET   7

// ----------------------------------------------------------------------------
// Controller APB register offsets
// ----------------------------------------------------------------------------
`define REG_CTRL             12'h000
`define REG_CTRL_WORD        12'h004
`define REG_STATUS           12'h008
`define REG_LEVELS           12'h00c
`define REG_RELAY            12'h010

// CTRL fields
`define CTRL_DIN_LSB         0
`define CTRL_STO_LSB         4
`define CTRL_BIT_FIELDBUS    6
`define CTRL_BIT_SAFE_STOP   7
`define CTRL_RESET           32'h0000_0000

`endif

// ---- inc/drive_io_pkg.sv ----
// Shared types for the drive I/O supervisor
package drive_io_pkg;

    typedef enum logic [2:0] {
        ST_SOD         = 3'b000,
        ST_READY       = 3'b001,
        ST_SWITCHED_ON = 3'b010,
        ST_OP_ENABLED  = 3'b011,
        ST_SAFETY      = 3'b100,
        ST_FAULT       = 3'b101
    } drive_state_t;

    typedef enum logic [1:0] {
        SS_IDLE  = 2'b00,
        SS_STOP  = 2'b01,
        SS_DELAY = 2'b10,
        SS_HOLD  = 2'b11
    } safe_stop_t;

endpackage

// ---- verif/drive_io_monitor.sv ----
// Concurrent checks on the link between drive and controller
`timescale 1ns/1ps
`default_nettype none
module drive_io_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [3:0]  din,
    input wire logic [1:0]  safe_torque_off,
    input wire logic        fieldbus_mode,
    input wire logic [15:0] ctrl_word,
    input wire logic        ctrl_word_valid,
    input wire logic [15:0] status_word,
    input wire logic [3:0]  dout,
    input wire logic [31:0] din_levels,
    input wire logic [31:0] dout_levels,
    input wire logic [1:0]  relay_cmd
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Link rules
    // ------------------------------------------------------------
    // One cycle of margin over the three-edge answer of the link
    chk_safety_bit_set: assert property ((safe_torque_off != 2'b00) [*5] |-> status_word[14])
        else $error("safety bit low under torque-off");
    chk_emergency_bit: assert property (din[2] [*5] |-> status_word[8])
        else $error("emergency bit low");
    chk_safety_code: assert property (status_word[14] |-> status_word[7:0] == 8'h00)
        else $error("state code wrong in safety");
    chk_safety_no_torque: assert property (status_word[14] |-> !dout[3])
        else $error("brake released in safety");
    chk_fault_not_ok: assert property (status_word[7:0] == 8'h08 |-> !dout[0])
        else $error("drive ok high in fault");
    chk_input_sync: assert property ($stable(din) [*4] |-> din_levels == {28'h0, din})
        else $error("input levels lag");
    chk_relay_readback: assert property ($stable(safe_torque_off) [*4] |-> relay_cmd == safe_torque_off)
        else $error("relay command wrong");
    chk_cw_shutdown: assert property (ctrl_word_valid && fieldbus_mode && status_word[7:0] == 8'h40
        && (ctrl_word & 16'h008f) == 16'h0006 && safe_torque_off == 2'b00 && relay_cmd == 2'b00
        |-> ##[1:2] status_word[7:0] == 8'h21)
        else $error("shutdown command not answered");
    cover property (status_word[7:0] == 8'h27);
    cover property (status_word[14]);
    cover property (status_word[7:0] == 8'h08);
endmodule
`default_nettype wire

// ---- verif/drive_io_safety_supervisor_tb.sv ----
// Bench for the drive supervisor and its APB controller
`timescale 1ns/1ps
`default_nettype none
`include "drive_io_params.svh"
module drive_io_safety_supervisor_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic        pready, pslverr, ev, fault = 1'b0, warn = 1'b0;
    logic [15:0] speed = 16'h0, vmax = 16'h3e8;
    logic        torque_enable, dynamic_brake, overspeed_alarm;
    logic [2:0]  drive_state;
    logic [15:0] cws [5] = '{16'h0f, 16'h06, 16'h07, 16'h0f, 16'h07};
    logic [2:0]  sts [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h2};
    int          n_errors = 0, checked = 0, n_brk = 0;
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (dynamic_brake === 1'b1) n_brk <= n_brk + 1;
    drive_io_if lk ();
    drive_supervisor #(.HW_RESET_HOLD(4)) i_drive_supervisor (.pclk(pclk), .presetn(presetn), .link(lk.device),
        .motor_speed(speed), .max_velocity(vmax), .fault_detected(fault), .warning_pending(warn),
        .torque_enable(torque_enable), .dynamic_brake(dynamic_brake), .overspeed_alarm(overspeed_alarm),
        .drive_state(drive_state));
    drive_controller #(.STO_DELAY(3)) i_drive_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lk.controller));
    drive_io_monitor i_drive_io_monitor (.pclk(pclk), .presetn(presetn), .din(lk.din), .safe_torque_off(lk.safe_torque_off),
        .fieldbus_mode(lk.fieldbus_mode), .ctrl_word(lk.ctrl_word), .ctrl_word_valid(lk.ctrl_word_valid),
        .status_word(lk.status_word), .dout(lk.dout), .din_levels(lk.din_levels),
        .dout_levels(lk.dout_levels), .relay_cmd(lk.relay_cmd));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hung;
        n_errors++;
        tally_and_finish();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) hung();
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ctl(input logic [31:0] d);
        apb(1'b1, `REG_CTRL, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rv, x);
        chk({31'h0, ev}, {31'h0, e});
    endtask
    task automatic st(input logic [2:0] s);
        for (int i = 0; i < 40 && drive_state !== s; i++) @(posedge pclk);
        chk(32'(drive_state), 32'(s));
        if (drive_state !== s) hung();
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`REG_STATUS, 32'h40, 1'b0);
        rdc(12'h100, 32'h0, 1'b1);
        ctl(32'h30);
        st(3'h4);
        rdc(`REG_STATUS, 32'h4000, 1'b0);
        rdc(`REG_RELAY, 32'h3, 1'b0);
        chk(32'(torque_enable), 32'h0);
        ctl(32'h0);
        st(3'h2);
        chk(32'(lk.dout[2]), 32'h1);
        ctl(32'h1);
        st(3'h3);
        repeat (2) @(posedge pclk);
        chk(32'(torque_enable & lk.dout[3]), 32'h1);
        ctl(32'h31);
        st(3'h4);
        ctl(32'h1);
        repeat (10) @(posedge pclk);
        chk(32'(drive_state), 32'h4);
        ctl(32'h0);
        st(3'h2);
        ctl(32'h1);
        st(3'h3);
        ctl(32'h5);
        st(3'h2);
        rdc(`REG_STATUS, 32'h0123, 1'b0);
        chk(32'(n_brk), 32'h1);
        chk(32'(lk.dout[2]), 32'h0);
        ctl(32'h0);
        ctl(32'h1);
        st(3'h3);
        ctl(32'h3);
        st(3'h2);
        ctl(32'h1);
        repeat (10) @(posedge pclk);
        chk(32'(drive_state), 32'h2);
        ctl(32'h0);
        ctl(32'h1);
        st(3'h3);
        ctl(32'h81);
        st(3'h4);
        ctl(32'h0);
        st(3'h2);
        ctl(32'h1);
        st(3'h3);
        speed <= 16'h44c;
        repeat (8) @(posedge pclk);
        chk(32'(overspeed_alarm), 32'h0);
        speed <= 16'h44d;
        st(3'h5);
        chk(32'(overspeed_alarm), 32'h1);
        rdc(`REG_STATUS, 32'h8, 1'b0);
        chk(32'(lk.dout[0]), 32'h0);
        speed <= 16'h0;
        // A short reset pulse must not clear the fault
        ctl(32'h8);
        ctl(32'h0);
        repeat (10) @(posedge pclk);
        chk(32'(drive_state), 32'h5);
        ctl(32'h8);
        for (int i = 0; i < 40 && drive_state === 3'h5; i++) @(posedge pclk);
        chk(32'(drive_state === 3'h5), 32'h0);
        ctl(32'h70);
        st(3'h4);
        ctl(32'h40);
        st(3'h0);
        foreach (cws[k]) begin
            apb(1'b1, `REG_CTRL_WORD, {16'h0, cws[k]});
            repeat (4) @(posedge pclk);
            st(sts[k]);
        end
        warn <= 1'b1;
        ctl(32'h41);
        rdc(`REG_CTRL, 32'h41, 1'b0);
        repeat (10) @(posedge pclk);
        chk(32'(drive_state), 32'h2);
        rdc(`REG_LEVELS, 32'h0007_0001, 1'b0);
        fault <= 1'b1;
        st(3'h5);
        tally_and_finish();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        hung();
    end
endmodule
`default_nettype wire
